//--- rtl/dac_port_pkg.sv
// Shared constants and types for the quad converter serial command port
package dac_port_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int SEL_MSB = 19;
    localparam int SEL_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int CHANNELS = 4;
    localparam int CODE_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;
    // Select-high gap between frames
    localparam int GAP_NS = 20;
    localparam int CLK_NS = 4;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    // Link clock half period, in system clocks, for the host divider
    localparam int HALF_DIV = 16;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_WRITE_INPUT = 4'h1,
        CMD_UPDATE_DAC = 4'h2,
        CMD_WRITE_UPDATE = 4'h3,
        CMD_POWER = 4'h4,
        CMD_LOAD_MASK = 4'h5,
        CMD_SOFT_RESET = 4'h6,
        CMD_CHAIN = 4'h8,
        CMD_READBACK = 4'h9,
        CMD_NOP_CHAIN = 4'hf
    } command_t;

    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [15:0] MID_CODE_12 = 16'h0800;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'h0;
endpackage

//--- rtl/dac_link_if.sv
// Serial link between host and converter
`timescale 1ns/100ps
`default_nettype none
interface dac_link_if;
    logic sync_n;
    logic sclk;
    logic serial_data_in;
    logic serial_data_out;
    logic load_outputs_n;
    modport device (
        input sync_n,
        input sclk,
        input serial_data_in,
        input load_outputs_n,
        output serial_data_out
    );
    modport host (
        output sync_n,
        output sclk,
        output serial_data_in,
        output load_outputs_n,
        input serial_data_out
    );
endinterface
`default_nettype wire

//--- rtl/sync2.sv
// Two flip-flop synchroniser for a bus of levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    // System
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_r <= '1;
            q <= '1;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- rtl/dac_device.sv
// Converter end: frame capture, command decode and channel registers
// Behaviour
// [R1] 24-bit frames, first bit is bit 23
// [R2] Command, channel select, then data word
// [R3] 12-bit variant ignores four trailing bits
// [R4] Data sampled on falling link clock edges
// [R5] Host frames writes with select low
// [R6] Command executes on select rising edge
// [R7] Short frame still executes as valid
// [R8] Host keeps select high 20 ns
// [R9] Nop and reserved codes do nothing
// [R10] Write input; transparent with load low
// [R11] Copy input to converter register
// [R12] Write both registers, ignore load pin
// [R13] Power, load mask, software reset
// [R14] Chain enable and readback select
// [R15] One-hot select, D C B A order
// [R16] Load low outside frame transfers all; channels set in the load mask hold
// [R17] Straight binary code per variant
// [R18] Reset gives known state
// [R19] Serial data output for chain, readback
// [R20] Reset level chosen by select pin
// [R21] Four independent channel register pairs
// [R22] Idle edges ignored, new frame clears
`timescale 1ns/100ps
`default_nettype none
module dac_device
    import dac_port_pkg::*;
#(
    parameter int RES = 16
) (
    // System
    input wire logic clock,
    input wire logic rst,
    // Link
    dac_link_if.device link,
    // Straps
    input wire logic reset_level_select,
    // Channel state
    output logic [CODE_W-1:0] dac_code [CHANNELS],
    output logic [7:0] power_bits,
    output logic chain_enable
);
    import dac_port_pkg::*;

    // Only the two converter widths are served
    if (RES != 16 && RES != 12)
    begin : bad_res
        $error("RES must be 16 or 12");
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] pins_s;
    sync2 #(.W(4)) u_sync (
        .clock(clock),
        .rst(rst),
        .d({link.sync_n, link.sclk, link.serial_data_in,
            link.load_outputs_n}),
        .q(pins_s)
    );
    wire sync_s = pins_s[3];
    wire sclk_s = pins_s[2];
    wire sdi_s = pins_s[1];
    wire load_s = pins_s[0];

    logic sync_d_r, sclk_d_r;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync_d_r <= 1'b1;
            sclk_d_r <= 1'b1;
        end
        else
        begin
            sync_d_r <= sync_s;
            sclk_d_r <= sclk_s;
        end
    end
    wire frame_start = sync_d_r & ~sync_s;
    wire frame_end = ~sync_d_r & sync_s;
    wire sclk_fall = sclk_d_r & ~sclk_s & ~sync_s; // [R4] [R22]
    wire sclk_rise = ~sclk_d_r & sclk_s & ~sync_s;

    ////////////////////////////////////////////////////////////////////
    // Shift register
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic sdo_r;
    always_comb
    begin
        shift_nxt = shift_r;
        if (frame_start)
            shift_nxt = '0; // [R22]
        else if (sclk_fall)
            shift_nxt = {shift_r[FRAME_BITS-2:0], sdi_s}; // [R1] [R4]
    end

    // Strap caught after reset release
    logic rsel_r, strap_done_r, soft_rst_r;
    logic strap_m_r, strap_s_r;
    wire [CODE_W-1:0] reset_code = rsel_r ?
        (RES == 16 ? MID_CODE : MID_CODE_12) : ZERO_CODE; // [R20]

    ////////////////////////////////////////////////////////////////////
    // Decode
    wire [3:0] cmd = shift_r[CMD_MSB:CMD_LSB]; // [R2]
    wire [3:0] sel = shift_r[SEL_MSB:SEL_LSB]; // [R15]
    wire [CODE_W-1:0] word = (RES == 16) ? shift_r[DATA_MSB:0] :
        {4'h0, shift_r[DATA_MSB:DATA_MSB-11]}; // [R3] [R17]
    wire do_write = frame_end && cmd == CMD_WRITE_INPUT; // [R6] [R7]
    wire do_update = frame_end && cmd == CMD_UPDATE_DAC;
    wire do_both = frame_end && cmd == CMD_WRITE_UPDATE;
    wire do_power = frame_end && cmd == CMD_POWER;
    wire do_mask = frame_end && cmd == CMD_LOAD_MASK;
    wire do_soft = frame_end && cmd == CMD_SOFT_RESET;
    wire do_chain = frame_end && cmd == CMD_CHAIN;
    wire do_rb = frame_end && cmd == CMD_READBACK; // [R9] others idle
    wire hw_load = ~load_s & sync_s; // [R16]

    logic [CODE_W-1:0] in_r [CHANNELS];
    logic [CODE_W-1:0] dac_r [CHANNELS];
    logic [3:0] mask_r;
    logic [1:0] rb_sel_r;
    logic rb_pending_r;

    function automatic logic [1:0] pick(input logic [3:0] s);
        unique case (s)
            4'h2: pick = 2'd1;
            4'h4: pick = 2'd2;
            4'h8: pick = 2'd3;
            default: pick = 2'd0;
        endcase
    endfunction

    // Strap pin resynchronised; settles while reset is held
    always_ff @(posedge clock)
    begin
        strap_m_r <= reset_level_select;
        strap_s_r <= strap_m_r;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rsel_r <= 1'b0;
            strap_done_r <= 1'b0;
            soft_rst_r <= 1'b1;
        end
        else
        begin
            strap_done_r <= 1'b1;
            if (!strap_done_r)
                rsel_r <= strap_s_r;
            soft_rst_r <= !strap_done_r || do_soft; // [R13] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channel registers
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : ch
            wire hit = sel[g]; // [R15] [R21]
            wire transp = ~load_s & ~mask_r[g];
            always_ff @(posedge clock)
            begin
                if (rst || soft_rst_r)
                begin
                    in_r[g] <= reset_code; // [R18] [R20]
                    dac_r[g] <= reset_code;
                end
                else
                begin
                    if ((do_write || do_both) && hit)
                        in_r[g] <= word; // [R10] [R12]
                    if (do_both && hit)
                        dac_r[g] <= word; // [R12]
                    else if (do_write && hit && transp)
                        dac_r[g] <= word; // [R10]
                    else if (do_update && hit)
                        dac_r[g] <= in_r[g]; // [R11]
                    else if (hw_load && !mask_r[g])
                        dac_r[g] <= in_r[g]; // [R16]
                end
            end
            assign dac_code[g] = dac_r[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Mode registers and serial output
    always_ff @(posedge clock)
    begin
        if (rst || soft_rst_r)
        begin
            power_bits <= POWER_RESET;
            mask_r <= MASK_RESET;
            chain_enable <= 1'b0;
            rb_sel_r <= 2'd0;
            rb_pending_r <= 1'b0;
            shift_r <= '0;
            sdo_r <= 1'b0;
        end
        else
        begin
            if (do_power)
                power_bits <= shift_r[7:0]; // [R13]
            if (do_mask)
                mask_r <= shift_r[3:0]; // [R13]
            if (do_chain)
                chain_enable <= shift_r[0]; // [R14]
            if (do_rb)
            begin
                rb_sel_r <= pick(sel); // [R14]
                rb_pending_r <= 1'b1;
            end
            else if (frame_end)
                rb_pending_r <= 1'b0;
            // Readback image loaded at frame start
            if (frame_start && rb_pending_r)
                shift_r <= {4'h0, dac_r[rb_sel_r], 4'h0};
            else
                shift_r <= shift_nxt;
            // Output changes on rising edge, read on falling
            if (sclk_rise && (chain_enable || rb_pending_r))
                sdo_r <= shift_r[FRAME_BITS-1]; // [R19]
        end
    end
    assign link.serial_data_out = sdo_r;
endmodule
`default_nettype wire

//--- rtl/dac_host.sv
// Host end: serialises 24-bit frames and drives the load pin
`timescale 1ns/100ps
`default_nettype none
module dac_host
    import dac_port_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Link
    dac_link_if.host link,
    // User request
    input wire logic req_valid,
    input wire logic [FRAME_BITS-1:0] req_frame,
    input wire logic load_pulse,
    output logic req_ready,
    output logic [FRAME_BITS-1:0] rx_frame,
    output logic rx_valid
);
    import dac_port_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_SHIFT = 3'b010,
        S_GAP = 3'b100
    } state_t;
    state_t st_r;
    logic [FRAME_BITS-1:0] tx_r, rx_r;
    logic [CNT_W-1:0] bits_r;
    logic [7:0] div_r;
    logic sclk_r, sync_r, load_r, sdo_m_r, sdo_s_r;

    wire tick = div_r == 8'(HALF_DIV - 1);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st_r <= S_IDLE;
            tx_r <= '0;
            rx_r <= '0;
            bits_r <= '0;
            div_r <= '0;
            sclk_r <= 1'b1;
            sync_r <= 1'b1;
            load_r <= 1'b1;
            req_ready <= 1'b0;
            rx_frame <= '0;
            rx_valid <= 1'b0;
            sdo_m_r <= 1'b0;
            sdo_s_r <= 1'b0;
        end
        else
        begin
            sdo_m_r <= link.serial_data_out;
            sdo_s_r <= sdo_m_r;
            rx_valid <= 1'b0;
            load_r <= ~(load_pulse & sync_r & st_r == S_IDLE); // [R16]
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            req_ready <= 1'b0;
            unique case (st_r)
                S_IDLE:
                begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready)
                    begin
                        tx_r <= req_frame; // [R1]
                        sync_r <= 1'b0; // [R5]
                        bits_r <= '0;
                        div_r <= '0;
                        req_ready <= 1'b0;
                        st_r <= S_SHIFT;
                    end
                end
                S_SHIFT:
                    if (tick)
                    begin
                        sclk_r <= ~sclk_r;
                        if (!sclk_r)
                        begin
                            // Rising edge: data moves half a period early
                            tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0}; // [R1]
                            if (bits_r == CNT_FULL)
                            begin
                                sync_r <= 1'b1; // [R5]
                                rx_frame <= rx_r;
                                rx_valid <= 1'b1;
                                bits_r <= '0;
                                st_r <= S_GAP;
                            end
                        end
                        else
                        begin
                            // Falling edge: device samples, host reads
                            rx_r <= {rx_r[FRAME_BITS-2:0], sdo_s_r};
                            bits_r <= bits_r + 5'h01;
                        end
                    end
                S_GAP:
                begin
                    bits_r <= bits_r + 5'h01;
                    if (bits_r == CNT_W'(GAP_CYC + HALF_DIV)) // [R8]
                        st_r <= S_IDLE;
                end
            endcase
        end
    end
    assign link.sclk = sclk_r;
    assign link.sync_n = sync_r;
    assign link.serial_data_in = tx_r[FRAME_BITS-1];
    assign link.load_outputs_n = load_r;
endmodule
`default_nettype wire

//--- bench/dac_link_checker.sv
// Wire-level assertions for the converter serial link
`timescale 1ns/100ps
`default_nettype none
module dac_link_checker (
    // System
    input wire logic clock,
    input wire logic rst,
    // Link
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic load_outputs_n
);
    logic [5:0] edges_r;
    logic sclk_q_r;
    logic sync_q_r;
    wire fall_edge = sclk_q_r && !sclk && !sync_n;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Falling link clock edges counted per frame
    always_ff @(posedge clock)
    begin
        sclk_q_r <= rst ? 1'b1 : sclk;
        sync_q_r <= rst ? 1'b1 : sync_n;
        if (rst || (sync_n && sync_q_r))
            edges_r <= 6'h0;
        else if (fall_edge)
            edges_r <= edges_r + 6'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_frame_count;
        $rose(sync_n) |-> edges_r == 6'h18;
    endproperty
    a_frame_count: assert property (p_frame_count)
        else $error("frame did not carry 24 clock edges");
    property p_data_hold;
        fall_edge |-> $stable(serial_data_in);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data changed at the sampling edge");
    property p_edge_spacing;
        $fell(sclk) |-> !sclk [*8];
    endproperty
    a_edge_spacing: assert property (p_edge_spacing)
        else $error("link clock low phase too short");
    property p_idle_clock;
        sync_n && sync_q_r |-> sclk;
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("link clock moved outside a frame");
    property p_start_high;
        $fell(sync_n) |-> sclk;
    endproperty
    a_start_high: assert property (p_start_high)
        else $error("frame began with link clock low");
    property p_frame_bound;
        $fell(sync_n) |-> ##[1:1000] $rose(sync_n);
    endproperty
    a_frame_bound: assert property (p_frame_bound)
        else $error("frame select not returned high");
    property p_gap;
        $rose(sync_n) |-> sync_n [*5];
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap between frames too short");
    property p_load_idle;
        !load_outputs_n |-> sync_n;
    endproperty
    a_load_idle: assert property (p_load_idle)
        else $error("load pin low inside a frame");
endmodule
`default_nettype wire

//--- bench/quad_dac_serial_command_port_test.sv
// Self-checking bench: host end driving converter end over the link
`timescale 1ns/100ps
`default_nettype none
module quad_dac_serial_command_port_test
    import dac_port_pkg::*;
;
    typedef struct {
        logic [15:0] code [CHANNELS];
        logic [7:0] pwr;
        logic chain;
        logic rb;
        logic [15:0] rb_code;
    } note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b1;
    logic req_valid = 1'b0;
    logic [23:0] req_frame = 24'h0;
    logic load_pulse = 1'b0;
    logic req_ready;
    logic [23:0] rx_frame;
    logic rx_valid;
    logic [CODE_W-1:0] dac_code [CHANNELS];
    logic [7:0] power_bits;
    logic chain_enable;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    note_t q [$];
    logic [23:0] wq [$];
    logic [15:0] in_m [CHANNELS];
    logic [15:0] dac_m [CHANNELS];
    logic [3:0] mask_m;
    logic [7:0] pwr_m;
    logic chain_m;
    logic rb_m = 1'b0;
    logic [1:0] rb_sel;
    logic [3:0] nops [8] = '{4'h0, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    logic sclk_q = 1'b1;
    logic sync_q = 1'b1;
    logic [23:0] shift = 24'h0;
    int nbits = 0;

    dac_link_if dac_link_if_i ();
    dac_host dac_host_i (.clock(clock), .rst(rst), .link(dac_link_if_i.host),
        .req_valid(req_valid), .req_frame(req_frame), .load_pulse(load_pulse),
        .req_ready(req_ready), .rx_frame(rx_frame), .rx_valid(rx_valid));
    dac_device dac_device_i (.clock(clock), .rst(rst),
        .link(dac_link_if_i.device), .reset_level_select(strap),
        .dac_code(dac_code), .power_bits(power_bits),
        .chain_enable(chain_enable));
    dac_link_checker dac_link_checker_i (.clock(clock), .rst(rst),
        .sync_n(dac_link_if_i.sync_n), .sclk(dac_link_if_i.sclk),
        .serial_data_in(dac_link_if_i.serial_data_in),
        .serial_data_out(dac_link_if_i.serial_data_out),
        .load_outputs_n(dac_link_if_i.load_outputs_n));

    initial
    begin
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [23:0] exp, logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic reset_model();
        for (int i = 0; i < CHANNELS; i++)
        begin
            in_m[i] = strap ? MID_CODE : ZERO_CODE;
            dac_m[i] = in_m[i];
        end
        pwr_m = 8'h0;
        mask_m = 4'h0;
        chain_m = 1'b0;
        rb_m = 1'b0;
    endtask

    // A hang here is caught by the cycle ceiling
    task automatic wait_idle();
        while (q.size() != 0 || req_ready !== 1'b1)
            @(negedge clock);
    endtask

    // Model update, notes, then one frame through the host
    task automatic send(logic [3:0] cmd, logic [3:0] sel, logic [15:0] data);
        note_t n;
        n.rb = rb_m;
        n.rb_code = dac_m[rb_sel];
        rb_m = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (sel[i] && (cmd == 4'h1 || cmd == 4'h3))
                in_m[i] = data;
            if (sel[i] && (cmd == 4'h2 || cmd == 4'h3))
                dac_m[i] = in_m[i];
        end
        if (cmd == 4'h4)
            pwr_m = data[7:0];
        if (cmd == 4'h5)
            mask_m = data[3:0];
        if (cmd == 4'h6)
            reset_model();
        if (cmd == 4'h8)
            chain_m = data[0];
        if (cmd == 4'h9)
        begin
            rb_m = 1'b1;
            rb_sel = 2'h0;
            for (int i = 0; i < CHANNELS; i++)
                if (sel == 4'(4'h1 << i))
                    rb_sel = 2'(i);
        end
        n.code = dac_m;
        n.pwr = pwr_m;
        n.chain = chain_m;
        q.push_back(n);
        wq.push_back({cmd, sel, data});
        @(negedge clock);
        req_valid = 1'b1;
        req_frame = {cmd, sel, data};
        // Ready seen settled before the edge that takes the request
        while (req_ready !== 1'b1)
            @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
    endtask

    task automatic load();
        wait_idle();
        for (int i = 0; i < CHANNELS; i++)
            if (!mask_m[i])
                dac_m[i] = in_m[i];
        load_pulse = 1'b1;
        repeat (4) @(negedge clock);
        load_pulse = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Wire sniffer: rebuilds each frame from the data line
    always @(negedge clock)
    begin
        if (!dac_link_if_i.sync_n && sclk_q && !dac_link_if_i.sclk)
        begin
            shift = {shift[22:0], dac_link_if_i.serial_data_in};
            nbits++;
        end
        if (!sync_q && dac_link_if_i.sync_n && wq.size() != 0)
        begin
            check("wire frame", wq.pop_front(), shift);
            check("wire bits", 24'h18, 24'(nbits));
            nbits = 0;
        end
        sclk_q = dac_link_if_i.sclk;
        sync_q = dac_link_if_i.sync_n;
    end

    // Result watcher
    initial
    begin
        note_t n;
        forever
        begin
            @(negedge clock);
            if (rx_valid === 1'b1 && q.size() != 0)
            begin
                n = q.pop_front();
                if (n.rb)
                    check("readback", {8'h0, n.rb_code},
                        {8'h0, rx_frame[19:4]});
                repeat (8) @(negedge clock);
                for (int i = 0; i < CHANNELS; i++)
                    check("dac_code", {8'h0, n.code[i]},
                        {8'h0, dac_code[i]});
                check("power_bits", 24'(n.pwr), 24'(power_bits));
                check("chain", 24'(n.chain), 24'(chain_enable));
            end
        end
    end

    initial
    begin
        void'($urandom(32'h26aecb0a));
        repeat (12) @(negedge clock);
        rst = 1'b0;
        reset_model();
        send(4'h0, 4'hf, 16'hffff);
        for (int i = 0; i < CHANNELS; i++)
            send(4'h1, 4'(4'h1 << i), 16'($urandom));
        send(4'h2, 4'h5, 16'h0);
        send(4'h3, 4'ha, 16'hffff);
        send(4'h3, 4'h3, 16'h0000);
        foreach (nops[k])
            send(nops[k], 4'hf, 16'($urandom));
        repeat (6)
            send(4'(1 + $urandom % 3), 4'($urandom), 16'($urandom));
        send(4'h5, 4'hf, 16'h0002);
        send(4'h1, 4'hf, 16'($urandom));
        load();
        send(4'h0, 4'h0, 16'h0);
        send(4'h5, 4'h0, 16'h0);
        load();
        send(4'h4, 4'h0, 16'($urandom));
        send(4'h8, 4'h0, 16'h0001);
        send(4'h9, 4'h4, 16'h0);
        send(4'hf, 4'h0, 16'h0);
        send(4'h8, 4'h0, 16'h0);
        send(4'h9, 4'h0, 16'h0);
        send(4'h0, 4'h0, 16'h0);
        send(4'h6, 4'h0, 16'h0);
        wait_idle();
        strap = 1'b0;
        rst = 1'b1;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        reset_model();
        send(4'h0, 4'hf, 16'h0);
        wait_idle();
        final_report();
    end
endmodule
`default_nettype wire
